// >>> design/ewp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "ewp_map.svh"
module ewp_host
  import ewp_pkg::*;
#(
  parameter logic [14:0] CMD_ADDR_A = 15'h5555,
  parameter logic [14:0] CMD_ADDR_B = 15'h2aaa,
  parameter logic [7:0]  CMD_DATA_1 = 8'haa,
  parameter logic [7:0]  CMD_DATA_2 = 8'h55,
  parameter logic [7:0]  CMD_DATA_ARM = 8'ha0,
  parameter logic [7:0]  CMD_DATA_CLR3 = 8'h80,
  parameter logic [7:0]  CMD_DATA_CLR6 = 8'h20,
  parameter int          BLC_CYC    = `EWP_BLC_CYC,
  parameter int          PROG_CYC   = `EWP_PROG_CYC,
  parameter int          STROBE_CYC = `EWP_STROBE_CYC
)(
  // Clock and reset.
  input  wire logic      clock,
  input  wire logic      rstn,
  // Request side.
  input  wire ewp_req_t  req,
  input  wire logic      req_valid,
  output logic           req_ready,
  output logic [7:0]     rd_data,
  output logic           rd_valid,
  output logic           busy,
  // Device pins.
  output ewp_pins_t      pins,
  input  wire logic [7:0] din
);
  // ==========================================================================
  // Sequencer
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SETUP = 5'b00010,
    S_LOW   = 5'b00100,
    S_HIGH  = 5'b01000,
    S_PROG  = 5'b10000
  } ewp_st_t;

  ewp_st_t     st_r,    st_nxt;
  logic [2:0]  step_r,  step_nxt;
  logic [2:0]  nsteps_r, nsteps_nxt;
  logic [22:0] cnt_r,   cnt_nxt;
  logic [7:0]  nbytes_r, nbytes_nxt;
  logic        page_r,  page_nxt;
  logic        rd_r,    rd_nxt;
  logic [14:0] addr_r,  addr_nxt;
  logic [7:0]  dat_r,   dat_nxt;
  logic [7:0]  rd_data_nxt;
  logic        rd_valid_nxt;
  logic [7:0]  din_s1_r, din_s2_r;
  // The taken request is held here; the live request port is only valid at the take.
  logic [14:0] ua_r,    ua_nxt;
  logic [7:0]  ud_r,    ud_nxt;
  logic        last_r,  last_nxt;

  // Command step decode, shared by arm and clear sequences.
  function automatic logic [22:0] cmd_word(input logic clr, input logic [2:0] s);
    logic [14:0] a;
    logic [7:0]  d;
    a = (s == 3'd1 || s == 3'd4) ? CMD_ADDR_B : CMD_ADDR_A;
    d = (s == 3'd1 || s == 3'd4) ? CMD_DATA_2 : CMD_DATA_1;
    if (s == 3'd2) d = clr ? CMD_DATA_CLR3 : CMD_DATA_ARM;
    if (s == 3'd5) d = CMD_DATA_CLR6;
    return {a, d};
  endfunction

  assign req_ready = (st_r == S_IDLE) ||
                     (st_r == S_HIGH && page_r && step_r == nsteps_r);
  assign busy      = (st_r != S_IDLE);

  always_comb begin
    st_nxt = st_r; step_nxt = step_r; nsteps_nxt = nsteps_r; cnt_nxt = cnt_r;
    nbytes_nxt = nbytes_r; page_nxt = page_r; rd_nxt = rd_r;
    addr_nxt = addr_r; dat_nxt = dat_r;
    rd_data_nxt = rd_data; rd_valid_nxt = 1'b0;
    ua_nxt = ua_r; ud_nxt = ud_r; last_nxt = last_r;
    case (st_r)
      S_IDLE: begin
        if (req_valid) begin
          rd_nxt = (req.op == EWP_OP_READ);
          step_nxt = 3'd0; cnt_nxt = '0; nbytes_nxt = 8'd0;
          page_nxt = (req.op != EWP_OP_READ) && (req.op != EWP_OP_CLEAR);
          // Prefix lengths: arm three, clear six, plain none.
          nsteps_nxt = (req.op == EWP_OP_ARMED) ? 3'd3 :
                       (req.op == EWP_OP_CLEAR) ? 3'd6 : 3'd0;
          addr_nxt = req.addr; dat_nxt = req.data;
          ua_nxt = req.addr; ud_nxt = req.data; last_nxt = req.last;
          if (req.op == EWP_OP_ARMED || req.op == EWP_OP_CLEAR)
            {addr_nxt, dat_nxt} = cmd_word(req.op == EWP_OP_CLEAR, 3'd0);
          st_nxt = S_SETUP;
        end
      end
      S_SETUP: st_nxt = S_LOW;
      S_LOW: begin
        cnt_nxt = cnt_r + 23'd1;
        if (cnt_r == 23'(STROBE_CYC - 1)) begin
          cnt_nxt = '0;
          if (rd_r) begin
            rd_data_nxt = din_s2_r;  rd_valid_nxt = 1'b1;  st_nxt = S_IDLE;
          end else st_nxt = S_HIGH;
        end
      end
      S_HIGH: begin
        // Counted from the strobe's rise; command steps follow back to back.
        cnt_nxt = cnt_r + 23'd1;
        if (step_r != nsteps_r) begin
          step_nxt = step_r + 3'd1;
          cnt_nxt = '0;
          if (step_r + 3'd1 != nsteps_r) begin
            {addr_nxt, dat_nxt} = cmd_word(nsteps_r == 3'd6, step_r + 3'd1);
            st_nxt = S_SETUP;
          end else if (page_r) begin
            addr_nxt = ua_r; dat_nxt = ud_r;
            st_nxt = S_SETUP;
          end else st_nxt = S_PROG;
        end else if (page_r && req_valid && req.addr[14:7] == addr_r[14:7]
                     && nbytes_r < 8'(`EWP_PAGE_MAX - 1)) begin
          nbytes_nxt = nbytes_r + 8'd1;
          addr_nxt = req.addr; dat_nxt = req.data; cnt_nxt = '0;
          last_nxt = req.last;
          st_nxt = S_SETUP;
        end else if (!page_r || last_r || cnt_r >= 23'(BLC_CYC)) begin
          cnt_nxt = '0; st_nxt = S_PROG;
        end
      end
      S_PROG: begin
        // Wait the full program time; after an armed write, protection then reapplies by itself.
        cnt_nxt = cnt_r + 23'd1;
        if (cnt_r >= 23'(PROG_CYC - 1)) begin
          cnt_nxt = '0; st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // ==========================================================================
  // Pin drive
  ewp_pins_t pins_nxt;
  always_comb begin
    pins_nxt = '{addr: addr_r, dout: dat_r, dout_oe: 1'b0,
                 ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    if (st_nxt == S_SETUP || st_nxt == S_LOW) begin
      pins_nxt.addr = addr_nxt;
      pins_nxt.dout = dat_nxt;
      pins_nxt.ce_n = 1'b0;
      // Reads lower the gate only; writes hold it high so a write is seen.
      pins_nxt.oe_n = !rd_nxt;
      pins_nxt.we_n = rd_nxt || (st_nxt != S_LOW);
      pins_nxt.dout_oe = !rd_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_IDLE; step_r <= '0; nsteps_r <= '0; cnt_r <= '0;
      nbytes_r <= '0; page_r <= 1'b0; rd_r <= 1'b0;
      addr_r <= '0; dat_r <= '0; rd_data <= '0; rd_valid <= 1'b0;
      pins <= '{addr: 15'h0000, dout: 8'h00, dout_oe: 1'b0,
                ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      din_s1_r <= '0; din_s2_r <= '0;
      ua_r <= '0; ud_r <= '0; last_r <= 1'b0;
    end else begin
      st_r <= st_nxt; step_r <= step_nxt; nsteps_r <= nsteps_nxt; cnt_r <= cnt_nxt;
      nbytes_r <= nbytes_nxt; page_r <= page_nxt; rd_r <= rd_nxt;
      addr_r <= addr_nxt; dat_r <= dat_nxt;
      rd_data <= rd_data_nxt; rd_valid <= rd_valid_nxt;
      pins <= pins_nxt;
      din_s1_r <= din; din_s2_r <= din_s1_r;
      ua_r <= ua_nxt; ud_r <= ud_nxt; last_r <= last_nxt;
    end
  end
endmodule // ewp_host
`default_nettype wire

// >>> inc/ewp_map.svh
// Functional notes
// - Host issues three command writes to fixed addresses before data writes. Here only EWP_OP_ARMED gets them; EWP_OP_WRITE goes out with no command writes.
// - Host does not interrupt an arming or clearing sequence with other accesses.
// - Host clears protection with six command writes, then waits one program time.
// - Host drives one device select low for every access; gate and strobe are shared.
// - Each further page byte starts within 100 us of the previous strobe fall.
`ifndef EWP_MAP_SVH
`define EWP_MAP_SVH
`define EWP_CLK_MHZ         100
`define EWP_BLC_MAX_US      100
`define EWP_BLC_MARGIN_US   10
`define EWP_BLC_CYC         ((`EWP_BLC_MAX_US - `EWP_BLC_MARGIN_US) * `EWP_CLK_MHZ)
`define EWP_PROG_TIME_US    5000
`define EWP_PROG_CYC        (`EWP_PROG_TIME_US * `EWP_CLK_MHZ)
`define EWP_STROBE_CYC      6
`define EWP_PAGE_MAX        128
`define EWP_BIT_POLL        7
`define EWP_BIT_TOGGLE      6
`endif

// >>> inc/ewp_pkg.sv
package ewp_pkg;
  typedef enum logic [1:0] {
    EWP_OP_WRITE = 2'h0,
    EWP_OP_ARMED = 2'h1,
    EWP_OP_CLEAR = 2'h2,
    EWP_OP_READ  = 2'h3
  } ewp_op_t;

  typedef struct packed {
    ewp_op_t     op;
    logic [14:0] addr;
    logic [7:0]  data;
    logic        last;
  } ewp_req_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  dout;
    logic        dout_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } ewp_pins_t;
endpackage

// >>> testbench/ewp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker.
module ewp_monitor
  import ewp_pkg::*;
(
  // Watched ports.
  input wire logic      clock,
  input wire logic      rstn,
  input wire ewp_req_t  req,
  input wire logic      req_valid,
  input wire logic      req_ready,
  input wire logic      rd_valid,
  input wire logic      busy,
  input wire ewp_pins_t pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic tk = req_valid && req_ready && !busy;
  write_gate_a: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("strobe low outside a write");
  drive_data_a: assert property (!pins.we_n |-> pins.dout_oe)
    else $error("strobe low with data undriven");
  read_gate_a: assert property (!pins.oe_n |-> pins.we_n && !pins.dout_oe)
    else $error("gate low during a write");
  strobe_width_a: assert property ($fell(pins.we_n) |-> !pins.we_n [*6] ##1 pins.we_n)
    else $error("strobe width wrong");
  write_start_a: assert property (tk && req.op == EWP_OP_WRITE |-> ##[1:2] !pins.ce_n ##[1:2] !pins.we_n)
    else $error("write not started");
  read_answer_a: assert property (tk && req.op == EWP_OP_READ |-> ##[8:9] rd_valid)
    else $error("read answer late");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid)
    else $error("read valid too long");
  idle_quiet_a: assert property (!busy |-> pins.we_n && pins.ce_n)
    else $error("pins active while idle");
endmodule // ewp_monitor
bind ewp_host ewp_monitor u_mon (.clock(clock), .rstn(rstn), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .rd_valid(rd_valid), .busy(busy), .pins(pins));
`default_nettype wire

// >>> testbench/ewp_dev.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Device model.
module ewp_dev
  import ewp_pkg::*;
(
  // Bus side.
  input wire logic      clock,
  input wire ewp_pins_t pins,
  output logic [7:0]    din
);
  logic [7:0] mem [0:32767];
  // Protection ignores rstn, as the real state survives power cycles.
  logic       prot = 1'b0;
  logic       arm  = 1'b0;
  logic       flp  = 1'b0;
  logic       wq   = 1'b1;
  logic [2:0] st   = 3'h0;
  int         idl  = 0;
  // Internal programming runs shorter than the host's wait, so reads see true data.
  int         pc   = 0;
  logic [14:0] la  = 15'h0000;
  logic       tg   = 1'b0;
  logic       oq   = 1'b1;
  wire logic  wr   = wq && !pins.we_n && !pins.ce_n && pins.oe_n;
  wire logic  ia   = pins.addr == 15'h5555;
  wire logic  ib   = pins.addr == 15'h2aaa;
  always @(posedge clock) begin
    wq <= pins.we_n;
    flp <= ~flp;
    idl <= wr ? 0 : idl + 1;
    pc <= wr ? 30 : (pc > 0 ? pc - 1 : 0);
    if (wr) la <= pins.addr;
    oq <= pins.oe_n;
    if (pc > 0 && oq && !pins.oe_n) tg <= ~tg;
    if (idl == 40) arm <= 1'b0;
    if (wr) begin
      st <= 3'h0;
      if ((st == 3'h0 || st == 3'h3) && ia && pins.dout == 8'haa) st <= st + 3'h1;
      else if ((st == 3'h1 || st == 3'h4) && ib && pins.dout == 8'h55) st <= st + 3'h1;
      else if (st == 3'h2 && ia && pins.dout == 8'ha0) {arm, prot} <= 2'h3;
      else if (st == 3'h2 && ia && pins.dout == 8'h80) st <= 3'h3;
      else if (st == 3'h5 && ia && pins.dout == 8'h20) prot <= 1'b0;
      else if (!prot || arm) mem[pins.addr] <= pins.dout;
    end
  end
  // A released bus shows a changing pattern, never the last value.
  assign din = (!pins.oe_n && !pins.ce_n) ?
               ((pc > 0 && pins.addr == la) ?
                {~mem[la][7], tg, mem[la][5:0]} : mem[pins.addr]) : {8{flp}};
endmodule // ewp_dev
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Testbench.
module tb_top;
  import ewp_pkg::*;
  logic       clock = 1'b0;
  logic       rstn  = 1'b0;
  ewp_req_t   req   = '0;
  logic       req_valid = 1'b0;
  logic       req_ready, rd_valid, busy;
  logic [7:0] rd_data, din;
  ewp_pins_t  pins;
  int         err_count = 0;
  int         comparisons = 0;
  ewp_host #(.BLC_CYC(20), .PROG_CYC(50)) dut (.clock(clock), .rstn(rstn), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .busy(busy), .pins(pins), .din(din));
  ewp_dev dev (.clock(clock), .pins(pins), .din(din));
  initial forever #5 clock = ~clock;
  task tally_and_finish();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task guard(int n);
    if (n >= 3000) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task put(ewp_op_t op, logic [14:0] a, logic [7:0] d, logic l);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{op, a, d, l};
    req_valid <= 1'b1;
    do @(negedge clock); while (req_ready !== 1'b1 && ++n < 3000);
    guard(n);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task idle();
    int n;
    n = 0;
    do @(negedge clock); while (busy !== 1'b0 && ++n < 3000);
    guard(n);
  endtask
  task wr(logic [14:0] a, logic [7:0] d);
    put(EWP_OP_WRITE, a, d, 1'b1);
    idle();
  endtask
  task rd(logic [14:0] a, logic [7:0] e);
    int n;
    n = 0;
    put(EWP_OP_READ, a, 8'h00, 1'b0);
    do @(negedge clock); while (rd_valid !== 1'b1 && ++n < 3000);
    guard(n);
    chk("rd_data", rd_data, e);
    idle();
  endtask
  task t_arm();
    put(EWP_OP_ARMED, 15'h0200, 8'h5a, 1'b0);
    wr(15'h0201, 8'ha5);
    rd(15'h0201, 8'ha5);
    wr(15'h0100, 8'hc3);
    rd(15'h0100, 8'h3c);
  endtask
  task t_keep();
    @(posedge clock) rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    wr(15'h0200, 8'h00);
    rd(15'h0200, 8'h5a);
  endtask
  task t_clear();
    put(EWP_OP_CLEAR, 15'h0000, 8'h00, 1'b0);
    idle();
    wr(15'h0100, 8'h77);
    rd(15'h0100, 8'h77);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    wr(15'h0100, 8'h3c);
    rd(15'h0100, 8'h3c);
    t_arm();
    t_keep();
    t_clear();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
